// *** smc_chk.sv ***
`timescale 1ns/1ps
module smc_chk
    import smc_pkg::*;
(
    input wire logic                        ref_clk_i,
    input wire logic                        rstn_i,
    input wire logic                        psel_i,
    input wire logic                        penable_i,
    input wire logic                        pwrite_i,
    input wire logic [smc_pkg::SMC_AW-1:0]  paddr_i,
    input wire logic [31:0]                 prdata_o,
    input wire logic                        pready_o,
    input wire logic                        pslverr_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    wire logic rd = pready_o && !pwrite_i && !pslverr_o;
    AST_PULSE: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    AST_ANSWER: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("access not answered");
    AST_IDLE: assert property (!(psel_i && penable_i) |=> !pready_o)
        else $error("answer without access");
    AST_W24: assert property (rd && paddr_i == 8'h00 |-> prdata_o[31:24] == 8'h00)
        else $error("tx ok count too wide");
    AST_W16: assert property (rd && paddr_i == 8'h04 |-> prdata_o[31:16] == 16'h0000)
        else $error("collision count too wide");
    AST_W8: assert property (rd && paddr_i == 8'h10 |-> prdata_o[31:8] == 24'h000000)
        else $error("checksum count too wide");
    AST_BAD: assert property (pready_o && paddr_i[1:0] != 2'h0 |-> pslverr_o)
        else $error("unaligned access accepted");
    AST_RST: assert property ($rose(rstn_i) |-> prdata_o == 32'h0 && !pready_o)
        else $error("outputs not clear after reset");
    cover property (rd && prdata_o == 32'h0000_00ff);
    cover property (pready_o && pslverr_o);
    cover property (pready_o && pwrite_i);
endmodule // smc_chk

bind smc_stat_counters smc_chk i_chk (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o));

// *** smc_mac_model.sv ***
`timescale 1ns/1ps
module smc_mac_model
(
    input  wire logic        clk_i,
    output logic             tx_done_o,
    output logic [4:0]       tx_coll_o,
    output logic [5:0]       tx_flag_o,
    output logic             rx_done_o,
    output logic [4:0]       rx_flag_o,
    output logic [13:0]      rx_len_o
);
    // status stays as a level between frames, like the engines
    initial {tx_done_o, tx_coll_o, tx_flag_o, rx_done_o, rx_flag_o, rx_len_o} = '0;
    task automatic tx(input logic [4:0] c, input logic [5:0] f);
        @(posedge clk_i);
        tx_done_o <= 1'b1;
        tx_coll_o <= c;
        tx_flag_o <= f;
        @(posedge clk_i);
        tx_done_o <= 1'b0;
    endtask
    task automatic rx(input logic [4:0] f, input logic [13:0] l);
        @(posedge clk_i);
        rx_done_o <= 1'b1;
        rx_flag_o <= f;
        rx_len_o <= l;
        @(posedge clk_i);
        rx_done_o <= 1'b0;
    endtask
endmodule // smc_mac_model

// *** smc_pkg.sv ***
package smc_pkg;

    localparam int unsigned SMC_NUM   = 17;
    localparam int unsigned SMC_MAXW  = 24;
    localparam int unsigned SMC_AW    = 8;
    localparam int unsigned SMC_LENW  = 14;
    localparam int unsigned SMC_COLLW = 5;

    // counter index; byte address is four times the index
    localparam int unsigned SMC_TX_OK      = 0;
    localparam int unsigned SMC_SCOL       = 1;
    localparam int unsigned SMC_MCOL       = 2;
    localparam int unsigned SMC_RX_OK      = 3;
    localparam int unsigned SMC_CRC_ERR    = 4;
    localparam int unsigned SMC_ALIGN_ERR  = 5;
    localparam int unsigned SMC_DEFER      = 6;
    localparam int unsigned SMC_LATE_COLL  = 7;
    localparam int unsigned SMC_EXCESS     = 8;
    localparam int unsigned SMC_CARRIER    = 9;
    localparam int unsigned SMC_UNDERRUN   = 10;
    localparam int unsigned SMC_SYMBOL     = 11;
    localparam int unsigned SMC_OVERSIZE   = 12;
    localparam int unsigned SMC_JABBER     = 13;
    localparam int unsigned SMC_UNDERSIZE  = 14;
    localparam int unsigned SMC_HEARTBEAT  = 15;
    localparam int unsigned SMC_DISCARD    = 16;

    localparam int unsigned SMC_WIDTH [SMC_NUM] = '{
        24, 16, 16, 24, 8, 8, 16, 8, 8, 8, 8, 8, 8, 8, 8, 8, 16
    };

    localparam logic [SMC_AW-1:0] SMC_CTRL_OFFSET = 8'h44;
    localparam int unsigned       SMC_CTRL_EN_BIT  = 0;
    localparam int unsigned       SMC_CTRL_CLR_BIT = 1;
    localparam logic              SMC_CTRL_EN_RST  = 1'b1;
    localparam logic [SMC_MAXW-1:0] SMC_CNT_RST    = 24'h000000;

    localparam logic [SMC_LENW-1:0]  SMC_LEN_MIN    = 14'h0040;
    localparam logic [SMC_LENW-1:0]  SMC_LEN_MAX    = 14'h05ee;
    localparam logic [SMC_COLLW-1:0] SMC_COLL_LIMIT = 5'h10;

    typedef struct packed {
        logic [SMC_NUM-1:0][SMC_MAXW-1:0] cnt;
        logic                             en;
        logic                             pready;
        logic                             pslverr;
        logic [31:0]                      prdata;
    } smc_state_t;

endpackage

// *** smc_stat_counters.sv ***
`timescale 1ns/1ps
module smc_stat_counters
    import smc_pkg::*;
#(
    // widths up to SMC_MAXW; defaults are the documented sizes
    // transmit counters
    parameter int unsigned TX_OK_W         = 24,
    parameter int unsigned SINGLE_COLL_W   = 16,
    parameter int unsigned MULTI_COLL_W    = 16,
    parameter int unsigned DEFER_W         = 16,
    parameter int unsigned LATE_COLL_W     = 8,
    parameter int unsigned EXCESS_COLL_W   = 8,
    parameter int unsigned CARRIER_W       = 8,
    parameter int unsigned UNDERRUN_W      = 8,
    parameter int unsigned HEARTBEAT_W     = 8,
    // receive counters
    parameter int unsigned RX_OK_W         = 24,
    parameter int unsigned CRC_ERR_W       = 8,
    parameter int unsigned ALIGN_ERR_W     = 8,
    parameter int unsigned SYMBOL_W        = 8,
    parameter int unsigned OVERSIZE_W      = 8,
    parameter int unsigned JABBER_W        = 8,
    parameter int unsigned UNDERSIZE_W     = 8,
    parameter int unsigned DISCARD_W       = 16
)
(
    input  wire logic                            ref_clk_i,
    input  wire logic                            rstn_i,
    // apb slave
    input  wire logic                            psel_i,
    input  wire logic                            penable_i,
    input  wire logic                            pwrite_i,
    input  wire logic [smc_pkg::SMC_AW-1:0]      paddr_i,
    input  wire logic [31:0]                     pwdata_i,
    output logic      [31:0]                     prdata_o,
    output logic                                 pready_o,
    output logic                                 pslverr_o,
    // transmit engine, one pulse per finished frame
    input  wire logic                            tx_done_i,
    input  wire logic [smc_pkg::SMC_COLLW-1:0]   tx_coll_count_i,
    input  wire logic                            tx_late_coll_i,
    input  wire logic                            tx_carrier_lost_i,
    input  wire logic                            tx_half_duplex_i,
    input  wire logic                            tx_underrun_i,
    input  wire logic                            tx_deferred_i,
    input  wire logic                            tx_heartbeat_missing_i,
    // receive engine, one pulse per finished frame
    input  wire logic                            rx_done_i,
    input  wire logic                            rx_addr_match_i,
    input  wire logic [smc_pkg::SMC_LENW-1:0]    rx_length_i,
    input  wire logic                            rx_crc_bad_i,
    input  wire logic                            rx_odd_bits_i,
    input  wire logic                            rx_symbol_err_i,
    input  wire logic                            rx_no_buffer_i
);
    import smc_pkg::*;

    smc_state_t                       st_reg;
    smc_state_t                       st_next;
    logic [SMC_NUM-1:0][SMC_MAXW-1:0] cnt_max;
    // next counts and read selects, one per counter
    logic [SMC_NUM-1:0][SMC_MAXW-1:0] cnt_upd;
    logic [SMC_NUM-1:0][SMC_MAXW-1:0] cnt_sel;
    logic [SMC_MAXW-1:0]              cnt_rd;
    logic [SMC_NUM-1:0]               inc;
    logic [SMC_NUM-1:0]               rd_clear;

    // widths in counter index order, each at most SMC_MAXW
    localparam int unsigned CNT_W [SMC_NUM] = '{
        TX_OK_W,
        SINGLE_COLL_W,
        MULTI_COLL_W,
        RX_OK_W,
        CRC_ERR_W,
        ALIGN_ERR_W,
        DEFER_W,
        LATE_COLL_W,
        EXCESS_COLL_W,
        CARRIER_W,
        UNDERRUN_W,
        SYMBOL_W,
        OVERSIZE_W,
        JABBER_W,
        UNDERSIZE_W,
        HEARTBEAT_W,
        DISCARD_W
    };

    // per-counter saturation value from its width
    for (genvar i = 0; i < SMC_NUM; i++)
    begin : g_max
        localparam logic [31:0] MAX32 = (32'h1 << CNT_W[i]) - 32'h1;
        assign cnt_max[i] = MAX32[SMC_MAXW-1:0];
    end

    // frame classification
    logic tx_ur;
    logic tx_abandon;
    logic tx_clean;
    logic rx_sym;
    logic rx_len_ok;
    logic rx_long;
    logic rx_short;
    logic rx_err;

    always_comb
    begin
        tx_ur      = tx_done_i & tx_underrun_i;
        tx_clean   = tx_done_i & ~tx_underrun_i;
        // sixteen collisions means the frame was given up
        tx_abandon = tx_coll_count_i >= SMC_COLL_LIMIT;
        rx_sym     = rx_done_i & rx_addr_match_i & rx_symbol_err_i;
        rx_len_ok  = (rx_length_i >= SMC_LEN_MIN) && (rx_length_i <= SMC_LEN_MAX);
        rx_long    = rx_length_i > SMC_LEN_MAX;
        rx_short   = rx_length_i < SMC_LEN_MIN;
        // odd bits only err through the crc, so crc covers alignment
        rx_err     = rx_crc_bad_i | rx_symbol_err_i;

        inc = '0;
        inc[SMC_TX_OK]     = tx_clean & ~tx_abandon;
        inc[SMC_SCOL]      = tx_clean & ~tx_carrier_lost_i
                             & (tx_coll_count_i == 5'h01);
        inc[SMC_MCOL]      = tx_clean & ~tx_carrier_lost_i & ~tx_abandon
                             & (tx_coll_count_i >= 5'h02);
        inc[SMC_DEFER]     = tx_clean & tx_deferred_i
                             & (tx_coll_count_i == 5'h00);
        // late collision, also in collision counts
        inc[SMC_LATE_COLL] = tx_clean & tx_late_coll_i & ~tx_carrier_lost_i;
        inc[SMC_EXCESS]    = tx_clean & tx_abandon & ~tx_carrier_lost_i;
        inc[SMC_CARRIER]   = tx_clean & tx_half_duplex_i & tx_carrier_lost_i
                             & ~tx_abandon;
        inc[SMC_UNDERRUN]  = tx_ur;
        inc[SMC_HEARTBEAT] = tx_clean & tx_heartbeat_missing_i;

        inc[SMC_RX_OK]     = rx_done_i & ~rx_sym & rx_addr_match_i & rx_len_ok
                             & ~rx_crc_bad_i;
        inc[SMC_CRC_ERR]   = rx_done_i & ~rx_sym & rx_addr_match_i & rx_len_ok
                             & rx_crc_bad_i & ~rx_odd_bits_i;
        inc[SMC_ALIGN_ERR] = rx_done_i & ~rx_sym & rx_addr_match_i & rx_len_ok
                             & rx_crc_bad_i & rx_odd_bits_i;
        inc[SMC_SYMBOL]    = rx_sym;
        // length classes ignore the address match on purpose
        // long and clean
        inc[SMC_OVERSIZE]  = rx_done_i & ~rx_sym & rx_long & ~rx_err;
        inc[SMC_JABBER]    = rx_done_i & ~rx_sym & rx_long & rx_err;
        inc[SMC_UNDERSIZE] = rx_done_i & ~rx_sym & rx_short & ~rx_err;
        inc[SMC_DISCARD]   = rx_done_i & ~rx_sym & rx_addr_match_i & rx_no_buffer_i;
    end

    // bus decode
    logic                     access;
    logic                     aligned;
    logic [SMC_AW-3:0]        word_idx;
    logic                     is_cnt;
    logic                     is_ctrl;
    logic                     rd_cnt;
    logic                     clr_all;

    always_comb
    begin
        // one wait state: answer lands the cycle after access starts
        access   = psel_i & penable_i & ~st_reg.pready;
        aligned  = paddr_i[1:0] == 2'b00;
        word_idx = paddr_i[SMC_AW-1:2];
        is_cnt   = aligned && (word_idx < SMC_NUM[SMC_AW-3:0]);
        is_ctrl  = paddr_i == SMC_CTRL_OFFSET;
        // a counter read clears on the capturing edge
        rd_cnt   = access & ~pwrite_i & is_cnt;
        // write-1 clear-all, self-clearing
        clr_all  = access & pwrite_i & is_ctrl & pwdata_i[SMC_CTRL_CLR_BIT];
    end

    // per-counter clear, count and read select
    for (genvar i = 0; i < SMC_NUM; i++)
    begin : g_cnt
        logic hit;

        // hit decodes this counter's word index
        assign hit         = word_idx == (SMC_AW-2)'(i);
        assign rd_clear[i] = (rd_cnt & hit) | clr_all;
        // and-or read mux avoids indexing past the last counter
        assign cnt_sel[i]  = (rd_cnt & hit) ? st_reg.cnt[i] : SMC_CNT_RST;

        // one saturating update per counter
        smc_cnt_next i_next
        (
            .cnt_i   (st_reg.cnt[i]),
            .max_i   (cnt_max[i]),
            .clear_i (rd_clear[i]),
            .inc_i   (inc[i]),
            .en_i    (st_reg.en),
            .next_o  (cnt_upd[i])
        );
    end

    always_comb
    begin
        cnt_rd = SMC_CNT_RST;
        // at most one select is live at a time
        for (int i = 0; i < SMC_NUM; i++)
        begin
            cnt_rd = cnt_rd | cnt_sel[i];
        end
    end

    always_comb
    begin
        st_next         = st_reg;
        st_next.pready  = 1'b0;
        // counts move every cycle, bus access or not
        st_next.cnt     = cnt_upd;

        if (access)
        begin
            st_next.pready  = 1'b1;
            st_next.pslverr = 1'b0;
            st_next.prdata  = 32'h00000000;
            if (!pwrite_i)
            begin
                if (is_cnt)
                begin
                    // read returns the value before clearing
                    st_next.prdata           = {8'h00, cnt_rd};
                end
                else if (is_ctrl)
                begin
                    // clear-all bit is a strobe, only enable reads back
                    st_next.prdata[SMC_CTRL_EN_BIT] = st_reg.en;
                end
                else
                begin
                    st_next.pslverr = 1'b1;
                end
            end
            else
            begin
                if (is_ctrl)
                begin
                    st_next.en = pwdata_i[SMC_CTRL_EN_BIT];
                end
                else if (!is_cnt)
                begin
                    // counters ignore writes quietly; only holes error
                    st_next.pslverr = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st_reg.cnt     <= '0;
            st_reg.en      <= SMC_CTRL_EN_RST;
            st_reg.pready  <= 1'b0;
            st_reg.pslverr <= 1'b0;
            st_reg.prdata  <= 32'h00000000;
        end
        else
        begin
            // counters and bus answer advance together
            st_reg <= st_next;
        end
    end

    assign prdata_o  = st_reg.prdata;
    assign pready_o  = st_reg.pready;
    assign pslverr_o = st_reg.pslverr;

endmodule // smc_stat_counters

// saturating next value for one counter; combinational,
// the state itself stays in the top module's struct
module smc_cnt_next
    import smc_pkg::*;
(
    input  wire logic [smc_pkg::SMC_MAXW-1:0] cnt_i,
    input  wire logic [smc_pkg::SMC_MAXW-1:0] max_i,
    input  wire logic                         clear_i,
    input  wire logic                         inc_i,
    input  wire logic                         en_i,
    output logic      [smc_pkg::SMC_MAXW-1:0] next_o
);
    import smc_pkg::*;

    logic [SMC_MAXW-1:0] base;

    always_comb
    begin
        // clear before counting, so an event in the clearing cycle
        // starts the new count instead of being lost
        base   = clear_i ? SMC_CNT_RST : cnt_i;
        next_o = base;
        // hold at all ones
        // max_i is the all-ones value of the counter's own width
        if (inc_i && en_i && (base != max_i))
        begin
            next_o = base + 24'h000001;
        end
    end

endmodule // smc_cnt_next

// *** smc_tb.sv ***
`timescale 1ns/1ps
module testbench;
    import smc_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, r;
    logic        pready, pslverr, e, txd, rxd;
    logic [4:0]  txc, rxf;
    logic [5:0]  txf;
    logic [13:0] rxl;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    always #2 clk = ~clk;
    smc_mac_model i_mac (.clk_i(clk), .tx_done_o(txd), .tx_coll_o(txc), .tx_flag_o(txf),
        .rx_done_o(rxd), .rx_flag_o(rxf), .rx_len_o(rxl));
    smc_stat_counters i_dut (.ref_clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .tx_done_i(txd), .tx_coll_count_i(txc),
        .tx_late_coll_i(txf[5]), .tx_carrier_lost_i(txf[4]), .tx_half_duplex_i(txf[3]),
        .tx_underrun_i(txf[2]), .tx_deferred_i(txf[1]), .tx_heartbeat_missing_i(txf[0]),
        .rx_done_i(rxd), .rx_addr_match_i(rxf[4]), .rx_length_i(rxl), .rx_crc_bad_i(rxf[3]),
        .rx_odd_bits_i(rxf[2]), .rx_symbol_err_i(rxf[1]), .rx_no_buffer_i(rxf[0]));
    task automatic end_sim;
        if (miscompares == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x)
        begin
            miscompares++;
            $display("MISMATCH %0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        cmp(r, x);
        cmp({31'h0, e}, {31'h0, a > 8'h44 || a[1:0] != 2'h0});
    endtask
    // one read per counter also clears it for the next frame
    task automatic all(input logic [16:0] m);
        for (int i = 0; i < SMC_NUM; i++)
            rd(8'(4 * i), {31'h0, m[i]});
    endtask
    task automatic ft(input logic [4:0] c, input logic [5:0] f, input logic [16:0] m);
        i_mac.tx(c, f);
        all(m);
    endtask
    task automatic fr(input logic [4:0] f, input logic [13:0] l, input logic [16:0] m);
        i_mac.rx(f, l);
        all(m);
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            miscompares++;
            end_sim;
        end
    end
    initial
    begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        all(17'h00000);
        rd(8'h44, 32'h1);
        ft(5'h00, 6'h00, 17'h00001);
        ft(5'h01, 6'h00, 17'h00003);
        ft(5'h0f, 6'h00, 17'h00005);
        ft(5'h10, 6'h00, 17'h00100);
        ft(5'h01, 6'h20, 17'h00083);
        ft(5'h00, 6'h02, 17'h00041);
        ft(5'h00, 6'h18, 17'h00201);
        ft(5'h00, 6'h01, 17'h08001);
        ft(5'h02, 6'h3f, 17'h00400);
        fr(5'h10, 14'h05ee, 17'h00008);
        fr(5'h18, 14'h0040, 17'h00010);
        fr(5'h1c, 14'h0064, 17'h00020);
        fr(5'h1b, 14'h07d0, 17'h00800);
        fr(5'h10, 14'h05ef, 17'h01000);
        fr(5'h08, 14'h05ef, 17'h02000);
        fr(5'h10, 14'h003f, 17'h04000);
        fr(5'h11, 14'h003f, 17'h14000);
        apb(1'b1, 8'h44, 32'h0);
        ft(5'h00, 6'h00, 17'h00000);
        apb(1'b1, 8'h44, 32'h1);
        i_mac.tx(5'h00, 6'h00);
        apb(1'b1, 8'h00, 32'h5);
        rd(8'h00, 32'h1);
        rd(8'h48, 32'h0);
        rd(8'h02, 32'h0);
        i_mac.tx(5'h01, 6'h00);
        apb(1'b1, 8'h44, 32'h3);
        all(17'h00000);
        rd(8'h44, 32'h1);
        i_mac.tx(5'h00, 6'h00);
        fork
            begin
                @(posedge clk);
                i_mac.tx(5'h00, 6'h00);
            end
            rd(8'h00, 32'h1);
        join
        rd(8'h00, 32'h1);
        i_mac.rx(5'h10, 14'h0040);
        apb(1'b1, 8'h44, 32'h0);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        all(17'h00000);
        rd(8'h44, 32'h1);
        repeat (260) i_mac.rx(5'h10, 14'h003f);
        rd(8'h38, 32'hff);
        rd(8'h38, 32'h0);
        end_sim;
    end
endmodule // testbench
